//--- see_consts.svh
`ifndef SEE_CONSTS_SVH
`define SEE_CONSTS_SVH

// =====================================================================
// clock and link timing
`define SEE_CLK_NS 8
`define SEE_SPIKE_NS 100
`define SEE_FILT_CYC ((`SEE_SPIKE_NS + `SEE_CLK_NS - 1) / `SEE_CLK_NS + 1)
`define SEE_T_WC_NS 5000000
`define SEE_WC_CYC (`SEE_T_WC_NS / `SEE_CLK_NS)
`define SEE_DIV_RST 16'h004E

// =====================================================================
// memory geometry and addressing
`define SEE_AW 13
`define SEE_MEM_BYTES 8192
`define SEE_PAGE_BYTES 32
`define SEE_PAGE_W 5
// type code of the address byte, value arbitrary
`define SEE_TYPE_CODE 4'h6

// =====================================================================
// controller register offsets
`define SEE_REG_CMD 8'h00
`define SEE_REG_TX 8'h04
`define SEE_REG_RX 8'h08
`define SEE_REG_STAT 8'h0C
`define SEE_REG_DIV 8'h10

// command bits
`define SEE_CMD_START 0
`define SEE_CMD_STOP 1
`define SEE_CMD_WR 2
`define SEE_CMD_RD 3
`define SEE_CMD_NACK 4

// status bits
`define SEE_STAT_BUSY 0
`define SEE_STAT_NACK 1

`endif

//--- see_pkg.sv
package see_pkg;
  // =====================================================================
  // device link states
  typedef enum logic [2:0] {d_idle, d_rx, d_ack, d_tx, d_rack, d_prog} see_dev_st_e;
  // controller sequencer states
  typedef enum logic [1:0] {m_idle, m_start, m_bit, m_stop} see_mst_st_e;
endpackage

//--- see_link_if.sv
interface see_link_if;
  // =====================================================================
  // bus wires; sda resolved from the open-drain enables, scl taken from the master
  logic scl;
  logic sda;
  logic m_scl_o;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;

  // scl straight from the master, sda wired-and with pull-up
  assign scl = m_scl_o;
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport mst (input sda, output m_scl_o, output m_sda_o, output m_sda_oe);
endinterface

//--- see_dev.sv
// Implementation choices: the APB slave port and the placing of the registers.
`include "see_consts.svh"

module see_dev
  import see_pkg::*;
#(
  parameter int unsigned WC_CYC = `SEE_WC_CYC,
  parameter logic [3:0] TYPE_CODE = `SEE_TYPE_CODE
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // two-wire link
  see_link_if.dev link,
  // strap pins
  input wire logic addr_sel,
  input wire logic write_prot,
  // status
  output logic prog_busy
);

  localparam int PW = $clog2(WC_CYC + 1);
  localparam int FW = $clog2(`SEE_FILT_CYC + 1);

  // =====================================================================
  // pin synchronisers: {wp, sel, sda, scl}
  logic [3:0] pin_raw;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;

  assign pin_raw = {write_prot, addr_sel, link.sda, link.scl};

  // two flops per pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 4'h3;
      sync2_ff <= 4'h3;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // =====================================================================
  // spike filters on scl and sda
  logic [1:0] flt_ff;
  wire logic [1:0] nxt_flt;
  logic [1:0] prv_ff;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_flt
      logic [FW-1:0] fcnt_ff;
      logic [FW-1:0] nxt_fcnt;
      logic nxt_lvl;

      // level accepted only after it held past the spike width
      always_comb begin
        nxt_fcnt = '0;
        nxt_lvl = flt_ff[gi];
        if (sync2_ff[gi] != flt_ff[gi]) begin
          if (fcnt_ff == FW'(`SEE_FILT_CYC - 1)) begin
            nxt_lvl = sync2_ff[gi];
          end else begin
            nxt_fcnt = fcnt_ff + 1'b1;
          end
        end
      end

      // one driver per filtered bit
      assign nxt_flt[gi] = nxt_lvl;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fcnt_ff <= '0;
        end else begin
          fcnt_ff <= nxt_fcnt;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_ff <= 2'h3;
      prv_ff <= 2'h3;
    end else begin
      flt_ff <= nxt_flt;
      prv_ff <= flt_ff;
    end
  end

  // =====================================================================
  // bus events from filtered lines
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic sda_f;
  logic sel_s;
  logic wp_s;

  assign sda_f = flt_ff[1];
  assign sel_s = sync2_ff[2];
  assign wp_s = sync2_ff[3];
  assign scl_rise = flt_ff[0] && !prv_ff[0];
  assign scl_fall = !flt_ff[0] && prv_ff[0];
  assign start_ev = flt_ff[0] && prv_ff[0] && prv_ff[1] && !flt_ff[1];
  assign stop_ev = flt_ff[0] && prv_ff[0] && !prv_ff[1] && flt_ff[1];

  // =====================================================================
  // address byte decode
  function automatic logic dev_match(input logic [7:0] b, input logic sel);
    dev_match = (b[7:4] == TYPE_CODE) && (b[2:1] == 2'b00) && (b[3] == sel);
  endfunction

  // =====================================================================
  // array and transfer state
  logic [7:0] mem [`SEE_MEM_BYTES];
  logic [7:0] pbuf_ff [`SEE_PAGE_BYTES];
  logic [7:0] nxt_pbuf [`SEE_PAGE_BYTES];
  logic [`SEE_PAGE_BYTES-1:0] pval_ff, nxt_pval;
  see_dev_st_e st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic [1:0] byte_ff, nxt_byte;
  logic rd_ff, nxt_rd;
  logic mack_ff, nxt_mack;
  logic wpend_ff, nxt_wpend;
  logic wpblk_ff, nxt_wpblk;
  logic oe_ff, nxt_oe;
  logic busy_ff, nxt_busy;
  logic [`SEE_AW-1:0] addr_ff, nxt_addr;
  logic [PW-1:0] pcnt_ff, nxt_pcnt;
  logic [7:0] rd_byte;
  logic mem_we;
  logic [`SEE_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [`SEE_PAGE_W-1:0] pidx;

  assign rd_byte = mem[addr_ff];
  assign pidx = pcnt_ff[`SEE_PAGE_W-1:0];

  // next-state for link, counter and page buffer
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_byte = byte_ff;
    nxt_rd = rd_ff;
    nxt_mack = mack_ff;
    nxt_wpend = wpend_ff;
    nxt_wpblk = wpblk_ff;
    nxt_oe = oe_ff;
    nxt_addr = addr_ff;
    nxt_pbuf = pbuf_ff;
    nxt_pval = pval_ff;
    nxt_pcnt = pcnt_ff;
    mem_we = 1'b0;
    mem_wa = addr_ff;
    mem_wd = pbuf_ff[0];
    if (st_ff == d_prog) begin
      // link ignored, no acknowledge until done
      nxt_pcnt = pcnt_ff + 1'b1;
      if (pcnt_ff < PW'(`SEE_PAGE_BYTES)) begin
        mem_we = pval_ff[pidx];
        mem_wa = {addr_ff[`SEE_AW-1:`SEE_PAGE_W], pidx};
        mem_wd = pbuf_ff[pidx];
      end
      if (pcnt_ff == PW'(WC_CYC - 1)) begin
        nxt_st = d_idle;
        nxt_pval = '0;
      end
    end else if (start_ev) begin
      // a start outside programming restarts the byte engine
      nxt_st = d_rx;
      nxt_cnt = 4'h0;
      nxt_byte = 2'h0;
      nxt_oe = 1'b0;
      nxt_wpend = 1'b0;
    end else if (stop_ev) begin
      nxt_oe = 1'b0;
      nxt_pcnt = '0;
      nxt_wpend = 1'b0;
      nxt_st = (wpend_ff && !wpblk_ff && !wp_s) ? d_prog : d_idle;
    end else begin
      case (st_ff)
        d_rx: begin
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_f};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == 4'h8) begin
            nxt_cnt = 4'h0;
            nxt_oe = 1'b1;
            nxt_st = d_ack;
            nxt_byte = (byte_ff == 2'h3) ? 2'h3 : byte_ff + 2'h1;
            case (byte_ff)
              2'h0: begin
                if (dev_match(sh_ff, sel_s)) begin
                  nxt_rd = sh_ff[0];
                  if (!sh_ff[0]) begin
                    nxt_pval = '0;
                    nxt_wpend = 1'b0;
                    nxt_wpblk = 1'b0;
                  end
                end else begin
                  nxt_oe = 1'b0;
                  nxt_st = d_idle;
                end
              end
              2'h1: nxt_addr[`SEE_AW-1:8] = sh_ff[`SEE_AW-9:0];
              2'h2: nxt_addr[7:0] = sh_ff;
              default: begin
                nxt_pbuf[addr_ff[`SEE_PAGE_W-1:0]] = sh_ff;
                nxt_pval[addr_ff[`SEE_PAGE_W-1:0]] = 1'b1;
                nxt_addr[`SEE_PAGE_W-1:0] = addr_ff[`SEE_PAGE_W-1:0] + 1'b1;
                nxt_wpend = 1'b1;
                nxt_wpblk = wpblk_ff || wp_s;
              end
            endcase
          end
        end
        d_ack: begin
          if (scl_fall && !rd_ff) begin
            nxt_oe = 1'b0;
            nxt_st = d_rx;
          end
        end
        d_tx: begin
          if (scl_fall) begin
            if (cnt_ff == 4'h7) begin
              nxt_oe = 1'b0;
              nxt_st = d_rack;
            end else begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_oe = !sh_ff[6];
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        d_rack: begin
          if (scl_rise) begin
            nxt_mack = sda_f;
          end else if (scl_fall && mack_ff) begin
            nxt_st = d_idle;
          end
        end
        default: begin
          nxt_oe = 1'b0;
        end
      endcase
      // load the counter byte after address ack or master ack
      if (scl_fall && ((st_ff == d_ack && rd_ff) || (st_ff == d_rack && !mack_ff))) begin
        nxt_sh = rd_byte;
        nxt_addr = addr_ff + 1'b1;
        nxt_oe = !rd_byte[7];
        nxt_cnt = 4'h0;
        nxt_st = d_tx;
      end
    end
    nxt_busy = (nxt_st == d_prog);
  end

  // register the link and counter state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= d_idle;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      byte_ff <= 2'h0;
      rd_ff <= 1'b0;
      mack_ff <= 1'b1;
      wpend_ff <= 1'b0;
      wpblk_ff <= 1'b0;
      oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      addr_ff <= '0;
      pval_ff <= '0;
      pcnt_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      byte_ff <= nxt_byte;
      rd_ff <= nxt_rd;
      mack_ff <= nxt_mack;
      wpend_ff <= nxt_wpend;
      wpblk_ff <= nxt_wpblk;
      oe_ff <= nxt_oe;
      busy_ff <= nxt_busy;
      addr_ff <= nxt_addr;
      pval_ff <= nxt_pval;
      pcnt_ff <= nxt_pcnt;
    end
  end

  // page buffer and array storage, no reset
  always_ff @(posedge pclk) begin
    pbuf_ff <= nxt_pbuf;
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // =====================================================================
  // outputs
  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe = oe_ff;
  assign prog_busy = busy_ff;

endmodule // see_dev

//--- see_mst.sv
`include "see_consts.svh"

module see_mst
  import see_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // two-wire link
  see_link_if.mst link
);

  // =====================================================================
  // state
  see_mst_st_e st_ff, nxt_st;
  logic [1:0] ph_ff, nxt_ph;
  logic [3:0] bit_ff, nxt_bit;
  logic [15:0] qcnt_ff, nxt_qcnt;
  logic [15:0] div_ff, nxt_div;
  logic [7:0] tx_ff, nxt_tx;
  logic [7:0] rx_ff, nxt_rx;
  logic [7:0] sh_ff, nxt_sh;
  logic rdop_ff, nxt_rdop;
  logic nackb_ff, nxt_nackb;
  logic nack_ff, nxt_nack;
  logic scl_ff, nxt_scl;
  logic oe_ff, nxt_oe;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic sda1_ff;
  logic sda2_ff;
  logic acc;
  logic tick;
  logic mapped;

  // sda pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda1_ff <= 1'b1;
      sda2_ff <= 1'b1;
    end else begin
      sda1_ff <= link.sda;
      sda2_ff <= sda1_ff;
    end
  end

  assign acc = psel && penable && pready_ff;
  assign tick = (st_ff != m_idle) && (qcnt_ff >= div_ff);
  assign mapped = (paddr == `SEE_REG_CMD) || (paddr == `SEE_REG_TX) || (paddr == `SEE_REG_RX)
    || (paddr == `SEE_REG_STAT) || (paddr == `SEE_REG_DIV);

  // =====================================================================
  // register access and bit sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_ph = ph_ff;
    nxt_bit = bit_ff;
    nxt_qcnt = (st_ff == m_idle || tick) ? 16'h0001 : qcnt_ff + 16'h0001;
    nxt_div = div_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_sh = sh_ff;
    nxt_rdop = rdop_ff;
    nxt_nackb = nackb_ff;
    nxt_nack = nack_ff;
    nxt_scl = scl_ff;
    nxt_oe = oe_ff;
    // one wait state, answer registered
    nxt_pready = psel && penable && !pready_ff;
    nxt_pslverr = psel && penable && !pready_ff && !mapped;
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      `SEE_REG_TX: nxt_prdata[7:0] = tx_ff;
      `SEE_REG_RX: nxt_prdata[7:0] = rx_ff;
      `SEE_REG_STAT: begin
        nxt_prdata[`SEE_STAT_BUSY] = (st_ff != m_idle);
        nxt_prdata[`SEE_STAT_NACK] = nack_ff;
      end
      `SEE_REG_DIV: nxt_prdata[15:0] = div_ff;
      default: nxt_prdata = 32'h0000_0000;
    endcase
    if (acc && pwrite) begin
      if (paddr == `SEE_REG_TX) nxt_tx = pwdata[7:0];
      if (paddr == `SEE_REG_DIV) nxt_div = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      // commands taken only while idle
      if (paddr == `SEE_REG_CMD && st_ff == m_idle) begin
        nxt_ph = 2'h0;
        nxt_bit = 4'h0;
        nxt_rdop = pwdata[`SEE_CMD_RD] && !pwdata[`SEE_CMD_WR];
        nxt_nackb = pwdata[`SEE_CMD_NACK];
        nxt_sh = pwdata[`SEE_CMD_WR] ? tx_ff : 8'hFF;
        if (pwdata[`SEE_CMD_START]) nxt_st = m_start;
        else if (pwdata[`SEE_CMD_WR] || pwdata[`SEE_CMD_RD]) nxt_st = m_bit;
        else if (pwdata[`SEE_CMD_STOP]) nxt_st = m_stop;
      end
    end
    if (tick) begin
      nxt_ph = ph_ff + 2'h1;
      case (st_ff)
        m_start: begin
          // release, clock high, data low, clock low
          if (ph_ff == 2'h0) nxt_oe = 1'b0;
          if (ph_ff == 2'h1) nxt_scl = 1'b1;
          if (ph_ff == 2'h2) nxt_oe = 1'b1;
          if (ph_ff == 2'h3) begin
            nxt_scl = 1'b0;
            nxt_st = m_idle;
          end
        end
        m_stop: begin
          if (ph_ff == 2'h0) nxt_oe = 1'b1;
          if (ph_ff == 2'h1) nxt_scl = 1'b1;
          if (ph_ff == 2'h2) nxt_oe = 1'b0;
          if (ph_ff == 2'h3) nxt_st = m_idle;
        end
        m_bit: begin
          if (ph_ff == 2'h0) begin
            nxt_scl = 1'b0;
            if (bit_ff == 4'h8) nxt_oe = rdop_ff && !nackb_ff;
            else nxt_oe = !rdop_ff && !sh_ff[7];
          end
          if (ph_ff == 2'h1) nxt_scl = 1'b1;
          if (ph_ff == 2'h2) begin
            if (bit_ff == 4'h8) nxt_nack = rdop_ff ? nackb_ff : sda2_ff;
            else nxt_sh = {sh_ff[6:0], sda2_ff};
          end
          if (ph_ff == 2'h3) begin
            nxt_scl = 1'b0;
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h8) begin
              nxt_oe = 1'b0;
              nxt_st = m_idle;
              if (rdop_ff) nxt_rx = sh_ff;
            end
          end
        end
        default: nxt_st = m_idle;
      endcase
    end
  end

  // register everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= m_idle;
      ph_ff <= 2'h0;
      bit_ff <= 4'h0;
      qcnt_ff <= 16'h0001;
      div_ff <= `SEE_DIV_RST;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      sh_ff <= 8'h00;
      rdop_ff <= 1'b0;
      nackb_ff <= 1'b0;
      nack_ff <= 1'b0;
      scl_ff <= 1'b1;
      oe_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      bit_ff <= nxt_bit;
      qcnt_ff <= nxt_qcnt;
      div_ff <= nxt_div;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      sh_ff <= nxt_sh;
      rdop_ff <= nxt_rdop;
      nackb_ff <= nxt_nackb;
      nack_ff <= nxt_nack;
      scl_ff <= nxt_scl;
      oe_ff <= nxt_oe;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // =====================================================================
  // outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign link.m_scl_o = scl_ff;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe = oe_ff;

endmodule // see_mst

//--- see_link_chk.sv
module see_link_chk #(
  parameter int unsigned WC_CYC = 64
) (
  // clock, reset and status
  input wire logic pclk,
  input wire logic presetn,
  input wire logic prog_busy,
  // resolved bus wires
  input wire logic scl,
  input wire logic sda,
  // driver halves of the bus
  input wire logic m_scl_o,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  // =====================================================================
  // programming length counter
  int unsigned busy_cnt_ff;
  int unsigned nxt_busy_cnt;

  // count cycles while programming runs
  always_comb begin
    nxt_busy_cnt = prog_busy ? busy_cnt_ff + 1 : 0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end

  // =====================================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_open_drain;
    !s_sda_o && !m_sda_o;
  endproperty
  property p_dev_change_low;
    $changed(s_sda_oe) |-> !scl;
  endproperty
  property p_dev_hold_after_fall;
    $fell(scl) |=> $stable(s_sda_oe) [*8];
  endproperty
  property p_busy_quiet;
    prog_busy |-> !s_sda_oe;
  endproperty
  property p_busy_len;
    $fell(prog_busy) |-> busy_cnt_ff == WC_CYC;
  endproperty
  property p_busy_from_idle;
    $rose(prog_busy) |-> scl && sda;
  endproperty
  property p_start_by_master;
    scl && $past(scl) && $fell(sda) |-> m_sda_oe;
  endproperty
  property p_ack_stands;
    $rose(s_sda_oe) |=> s_sda_oe [*8];
  endproperty

  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  a_dev_change_low: assert property (p_dev_change_low) else $error("device data moved with clock high");
  a_dev_hold_after_fall: assert property (p_dev_hold_after_fall) else $error("device data moved too early");
  a_busy_quiet: assert property (p_busy_quiet) else $error("device drove data while programming");
  a_busy_len: assert property (p_busy_len) else $error("programming time wrong");
  a_busy_from_idle: assert property (p_busy_from_idle) else $error("programming began on a busy bus");
  a_start_by_master: assert property (p_start_by_master) else $error("device made a start");
  a_ack_stands: assert property (p_ack_stands) else $error("device pull too short");

  // main scenarios seen
  c_ack: cover property ($rose(s_sda_oe));
  c_prog: cover property ($rose(prog_busy));
  c_start: cover property (scl && $fell(sda));
endmodule // see_link_chk

//--- serial_eeprom_slave_interface_tb_top.sv
`include "see_consts.svh"

module serial_eeprom_slave_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // signals and model
  localparam int WC = 2000;
  logic pclk, presetn, addr_sel, write_prot, prog_busy;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  int fails, checked, cyc, seed, ctr;
  logic [7:0] mdl [0:8191];
  logic busy_seen, perr;

  // =====================================================================
  // the two ends and the checker
  see_link_if link_inst();
  see_dev #(.WC_CYC(WC)) see_dev_inst (.pclk(pclk), .presetn(presetn), .link(link_inst),
    .addr_sel(addr_sel), .write_prot(write_prot), .prog_busy(prog_busy));
  see_mst see_mst_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_inst));
  see_link_chk #(.WC_CYC(WC)) see_link_chk_inst (.pclk(pclk), .presetn(presetn), .prog_busy(prog_busy),
    .scl(link_inst.scl), .sda(link_inst.sda), .m_scl_o(link_inst.m_scl_o), .m_sda_o(link_inst.m_sda_o),
    .m_sda_oe(link_inst.m_sda_oe), .s_sda_o(link_inst.s_sda_o), .s_sda_oe(link_inst.s_sda_oe));

  // clock, timeout and programming watch
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (prog_busy === 1'b1) busy_seen <= 1'b1;
    if (cyc == 100000) begin
      fails++;
      stop_test();
    end
  end

  // =====================================================================
  // shared tasks
  task automatic stop_test();
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, released the edge after pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // one link command, waits for idle, returns nack and received byte
  task automatic op(input logic [4:0] c, input logic [7:0] tx, output logic nk, output logic [7:0] rx);
    logic [31:0] q;
    if (c[2]) apb(`SEE_REG_TX, 1'b1, {24'h000000, tx}, q);
    apb(`SEE_REG_CMD, 1'b1, {27'h0000000, c}, q);
    do apb(`SEE_REG_STAT, 1'b0, 32'h00000000, q); while (q[`SEE_STAT_BUSY] !== 1'b0);
    nk = q[`SEE_STAT_NACK];
    apb(`SEE_REG_RX, 1'b0, 32'h00000000, q);
    rx = q[7:0];
  endtask

  task automatic addr_byte(input logic sel, input logic rw, output logic nk);
    logic [7:0] d;
    op(5'h01, 8'h00, nk, d);
    op(5'h04, {`SEE_TYPE_CODE, sel, 2'b00, rw}, nk, d);
  endtask

  // write n random bytes at a, then poll until acknowledged
  task automatic wr_bytes(input logic [15:0] a, input int n, input logic prog);
    logic nk;
    logic [7:0] d, rx;
    int np;
    addr_byte(addr_sel, 1'b0, nk);
    chk(nk, 0);
    op(5'h04, a[15:8], nk, rx);
    chk(nk, 0);
    op(5'h04, a[7:0], nk, rx);
    chk(nk, 0);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      op(5'h04, d, nk, rx);
      chk(nk, 0);
      if (!write_prot) mdl[{a[12:5], 5'(a[4:0] + i)}] = d;
    end
    ctr = {a[12:5], 5'(a[4:0] + n)};
    busy_seen = 1'b0;
    op(5'h02, 8'h00, nk, rx);
    np = 0;
    do begin
      addr_byte(addr_sel, 1'b0, nk);
      op(5'h02, 8'h00, d[0], rx);
      np += nk;
    end while (nk === 1'b1 && np < 20);
    chk(np > 0, prog);
    chk(busy_seen, prog);
  endtask

  // read n bytes from the counter, master ack on all but the last
  task automatic rd_bytes(input int n);
    logic nk;
    logic [7:0] rx;
    for (int i = 0; i < n; i++) begin
      op((i == n - 1) ? 5'h18 : 5'h08, 8'h00, nk, rx);
      chk(rx, mdl[ctr]);
      ctr = (ctr + 1) % 8192;
    end
    op(5'h02, 8'h00, nk, rx);
  endtask

  task automatic cur_rd(input int n);
    logic nk;
    addr_byte(addr_sel, 1'b1, nk);
    chk(nk, 0);
    rd_bytes(n);
  endtask

  task automatic rand_rd(input logic [15:0] a, input int n);
    logic nk;
    logic [7:0] rx;
    addr_byte(addr_sel, 1'b0, nk);
    op(5'h04, a[15:8], nk, rx);
    op(5'h04, a[7:0], nk, rx);
    ctr = a[12:0];
    cur_rd(n);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic [15:0] a;
    logic nk;
    logic [7:0] rx;
    seed = 47042;
    fails = 0;
    checked = 0;
    cyc = 0;
    presetn = 1'b0;
    addr_sel = 1'b0;
    write_prot = 1'b0;
    busy_seen = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(`SEE_REG_DIV, 1'b1, 32'h00000010, q);
    // divider reads back, unmapped word answers with error and zero
    apb(`SEE_REG_DIV, 1'b0, 32'h00000000, q);
    chk(q, 32'h00000010);
    chk(perr, 1'b0);
    apb(8'h14, 1'b0, 32'h00000000, q);
    chk(perr, 1'b1);
    chk(q, 32'h00000000);
    // byte write with junk in the upper address bits
    a = 16'($random(seed));
    wr_bytes(a, 1, 1'b1);
    rand_rd(a ^ 16'hE000, 1);
    // known bytes at both ends of the array, read across the top
    wr_bytes(16'h0000, 4, 1'b1);
    wr_bytes(16'h1FFE, 2, 1'b1);
    rand_rd(16'h1FFE, 4);
    cur_rd(1);
    // page write of 33 bytes wraps and overwrites the first
    wr_bytes(16'h015E, 33, 1'b1);
    rand_rd(16'h015C, 4);
    // protected write is acknowledged but leaves the array alone
    write_prot <= 1'b1;
    @(posedge pclk);
    wr_bytes(16'h0001, 1, 1'b0);
    write_prot <= 1'b0;
    @(posedge pclk);
    rand_rd(16'h0000, 2);
    // start, nine released clocks, start: pending write data dropped
    busy_seen = 1'b0;
    addr_byte(addr_sel, 1'b0, nk);
    op(5'h04, 8'h00, nk, rx);
    op(5'h04, 8'h02, nk, rx);
    op(5'h04, ~mdl[2], nk, rx);
    op(5'h01, 8'h00, nk, rx);
    op(5'h18, 8'h00, nk, rx);
    op(5'h01, 8'h00, nk, rx);
    op(5'h02, 8'h00, nk, rx);
    rand_rd(16'h0002, 1);
    chk(busy_seen, 1'b0);
    // other select value is ignored, then the pin moves the address
    addr_byte(1'b1, 1'b0, nk);
    chk(nk, 1);
    op(5'h02, 8'h00, nk, rx);
    addr_sel <= 1'b1;
    @(posedge pclk);
    wr_bytes(16'h0003, 1, 1'b1);
    rand_rd(16'h0003, 1);
    addr_byte(1'b0, 1'b1, nk);
    chk(nk, 1);
    op(5'h02, 8'h00, nk, rx);
    // second reset clears the counter
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(`SEE_REG_DIV, 1'b1, 32'h00000010, q);
    ctr = 0;
    cur_rd(2);
    stop_test();
  end
endmodule // serial_eeprom_slave_interface_tb_top
